// *** src/xpa_core.sv ***
// Purpose: 24-bit external data address forming, dual data pointer, strobe
//          stretch control and timed-access protection
// Assumes: core reports each pointer instruction by a one-cycle done pulse and
//          register writes on the sfr request group; inputs synchronous to clk
// Notes:   register reads answer one clock after the address is presented
`timescale 1ns/100ps
module xpa_core (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire xpa_pkg::xpa_sfr_req_t sfr,
  output logic [7:0]                 sfr_rdata,
  input  wire xpa_pkg::xpa_op_t      op,
  input  wire logic [23:0]           load_value,
  input  wire xpa_pkg::xpa_xmove_t   xmove,
  output logic [23:0]                ext_data_address,
  output logic                       ext_read_strobe,
  output logic                       ext_write_strobe,
  output logic                       xmove_busy,
  output logic                       xmove_done,
  output logic [23:0]                active_pointer,
  output logic [1:0]                 address_mode,
  output logic                       protect_open
);
  import xpa_pkg::*;

  typedef struct packed {
    logic [15:0]          dp0;
    logic [15:0]          dp1;
    logic [7:0]           ext0;
    logic [7:0]           ext1;
    logic [7:0]           ind_hi;
    logic [7:0]           ind_mid;
    logic                 sel;
    logic                 tog_en;
    logic [1:0]           dir;
    logic [7:0]           clk_ctl;
    logic [AMODE_W-1:0]   amode;
    logic [7:0]           wdog;
    xpa_lock_t            lock;
    logic [23:0]          addr;
    logic [7:0]           rdata;
  } xpa_core_state_t;

  xpa_core_state_t s;
  xpa_core_state_t next_s;

  logic        wr_ok;
  logic        key_wr;
  logic        toggles;
  logic        move_start;
  logic        strobe_busy;
  logic [15:0] sel_ptr;
  logic [7:0]  sel_ext;
  logic [7:0]  rd_mux;

  assign sel_ptr = s.sel ? s.dp1 : s.dp0;
  assign sel_ext = s.sel ? s.ext1 : s.ext0;

  assign key_wr     = sfr.wr && (sfr.addr == ADDR_UNLOCK_KEY);
  assign move_start = xmove.req && !strobe_busy;
  assign wr_ok      = (s.lock == XPA_LK_OPEN) && sfr.direct;

  always_comb begin
    unique case (op.kind)
      XPA_OP_INC, XPA_OP_LOAD, XPA_OP_MOVC, XPA_OP_MOVX_PTR: toggles = 1'b1;
      default:                                               toggles = 1'b0;
    endcase
  end

  // read mux; protected registers read freely, reserved and unused bits as zero
  always_comb begin
    unique case (sfr.addr)
      ADDR_PTR0_LOW:    rd_mux = s.dp0[7:0];
      ADDR_PTR0_HIGH:   rd_mux = s.dp0[15:8];
      ADDR_PTR1_LOW:    rd_mux = s.dp1[7:0];
      ADDR_PTR1_HIGH:   rd_mux = s.dp1[15:8];
      ADDR_PTR_SELECT:  rd_mux = {s.dir, s.tog_en, 4'h0, s.sel};
      ADDR_CLK_STRETCH: rd_mux = s.clk_ctl;
      ADDR_PTR0_EXT:    rd_mux = s.ext0;
      ADDR_PTR1_EXT:    rd_mux = s.ext1;
      ADDR_IND_MIDDLE:  rd_mux = s.ind_mid;
      ADDR_IND_UPPER:   rd_mux = s.ind_hi;
      ADDR_ADDR_MODE:   rd_mux = {6'h00, s.amode};
      ADDR_WATCHDOG:    rd_mux = s.wdog;
      default:          rd_mux = 8'h00;
    endcase
  end

  // next state: register writes first, instruction effects override them
  always_comb begin
    next_s       = s;
    next_s.rdata = rd_mux;
    if (sfr.wr) begin
      unique case (sfr.addr)
        ADDR_PTR0_LOW:    next_s.dp0[7:0]  = sfr.wdata;
        ADDR_PTR0_HIGH:   next_s.dp0[15:8] = sfr.wdata;
        ADDR_PTR1_LOW:    next_s.dp1[7:0]  = sfr.wdata;
        ADDR_PTR1_HIGH:   next_s.dp1[15:8] = sfr.wdata;
        ADDR_PTR_SELECT: begin
          next_s.sel = sfr.wdata[SEL_BIT];
          next_s.tog_en = sfr.wdata[TOGGLE_EN_BIT];
          next_s.dir = {sfr.wdata[DIR1_BIT], sfr.wdata[DIR0_BIT]};
        end
        ADDR_CLK_STRETCH: next_s.clk_ctl = sfr.wdata;
        ADDR_PTR0_EXT:    next_s.ext0    = sfr.wdata;
        ADDR_PTR1_EXT:    next_s.ext1    = sfr.wdata;
        ADDR_IND_MIDDLE:  next_s.ind_mid = sfr.wdata;
        ADDR_IND_UPPER:   next_s.ind_hi  = sfr.wdata;
        ADDR_ADDR_MODE: begin
          if (wr_ok) begin
            next_s.amode = sfr.wdata[AMODE_W-1:0];
          end
        end
        ADDR_WATCHDOG: begin
          if (wr_ok) begin
            next_s.wdog = sfr.wdata;
          end
        end
        default: ;
      endcase
    end

    unique case (s.lock)
      XPA_LK_IDLE: begin
        if (key_wr && sfr.wdata == UNLOCK_FIRST) begin
          next_s.lock = XPA_LK_KEY1;
        end
      end
      XPA_LK_KEY1: begin
        if (key_wr) begin
          if (sfr.wdata == UNLOCK_SECOND) begin
            next_s.lock = op.done ? XPA_LK_OPEN : XPA_LK_KEY2;
          end else if (sfr.wdata != UNLOCK_FIRST) begin
            next_s.lock = XPA_LK_IDLE;
          end
        end
      end
      // second key written, waiting for that instruction to end
      XPA_LK_KEY2: begin
        if (op.done) begin
          next_s.lock = XPA_LK_OPEN;
        end
      end
      XPA_LK_OPEN: begin
        if (op.done) begin
          next_s.lock = XPA_LK_IDLE;
        end
      end
      default: next_s.lock = XPA_LK_IDLE;
    endcase

    if (move_start && !xmove.use_ri) begin
      next_s.addr = {sel_ext, sel_ptr};
    end
    if (move_start && xmove.use_ri) begin
      next_s.addr = {s.ind_hi, s.ind_mid, xmove.ri_value};
    end

    if (op.done) begin
      if (op.kind == XPA_OP_INC) begin
        if (!s.sel) begin
          next_s.dp0 = s.dir[0] ? s.dp0 - 16'h0001 : s.dp0 + 16'h0001;
        end else begin
          next_s.dp1 = s.dir[1] ? s.dp1 - 16'h0001 : s.dp1 + 16'h0001;
        end
      end
      if (op.kind == XPA_OP_LOAD) begin
        if (!s.sel) begin
          next_s.dp0 = load_value[15:0];
        end else begin
          next_s.dp1 = load_value[15:0];
        end
        // 24-bit load also fills the extension in flat mode
        if (s.amode[AMODE_FLAT] && !s.sel) begin
          next_s.ext0 = load_value[23:16];
        end
        if (s.amode[AMODE_FLAT] && s.sel) begin
          next_s.ext1 = load_value[23:16];
        end
      end
      if (s.tog_en && toggles) begin
        next_s.sel = ~s.sel;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s         <= '0;
      s.dp0     <= RST_POINTER;
      s.dp1     <= RST_POINTER;
      s.clk_ctl <= RST_CLK_STRETCH;
      s.wdog    <= RST_BYTE;
      s.lock    <= XPA_LK_IDLE;
    end else begin
      s <= next_s;
    end
  end

  xpa_strobe #(
    .STRETCH_W (STRETCH_W)
  ) u_strobe (
    .clk       (clk),
    .rst       (rst),
    .start     (move_start),
    .write     (xmove.write),
    .width     (s.clk_ctl[STRETCH_W-1:0]),
    .rd_strobe (ext_read_strobe),
    .wr_strobe (ext_write_strobe),
    .busy      (strobe_busy),
    .done      (xmove_done)
  );

  assign ext_data_address = s.addr;
  assign xmove_busy       = strobe_busy;
  assign active_pointer   = {sel_ext, sel_ptr};
  assign address_mode     = s.amode;
  assign protect_open     = (s.lock == XPA_LK_OPEN);
  assign sfr_rdata        = s.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ptr_upper_a: assert property (move_start && !xmove.use_ri |=>
    s.addr == {$past(sel_ext), $past(sel_ptr)})
    else $error("pointer move address not from selected pointer");
  ind_upper_a: assert property (move_start && xmove.use_ri |=>
    s.addr[23:8] == {$past(s.ind_hi), $past(s.ind_mid)})
    else $error("indirect move upper bits wrong");
  sel_toggle_a: assert property (op.done && s.tog_en && toggles |=> s.sel != $past(s.sel))
    else $error("select bit failed to toggle");
  sel_hold_a: assert property (op.done && !s.tog_en && !(sfr.wr &&
    sfr.addr == ADDR_PTR_SELECT) |=> s.sel == $past(s.sel))
    else $error("select bit changed with toggle disabled");
  ptr0_step_a: assert property (op.done && op.kind == XPA_OP_INC && !s.sel &&
    !sfr.wr |=> s.dp0 == ($past(s.dir[0]) ? $past(s.dp0) - 16'h0001 : $past(s.dp0) + 16'h0001))
    else $error("first pointer stepped the wrong way");
  locked_write_a: assert property (sfr.wr && sfr.addr == ADDR_ADDR_MODE &&
    s.lock != XPA_LK_OPEN |=> s.amode == $past(s.amode))
    else $error("locked address mode register changed");
  one_instr_a: assert property (s.lock == XPA_LK_OPEN && op.done |=> !protect_open)
    else $error("protection not restored after one instruction");
  open_seq_a: assert property (s.lock == XPA_LK_KEY1 && key_wr &&
    sfr.wdata == UNLOCK_SECOND && op.done |=> protect_open)
    else $error("valid key sequence did not open protection");
  stretch_rst_a: assert property ($past(rst) |-> s.clk_ctl == RST_CLK_STRETCH)
    else $error("stretch register reset value wrong");
  read_free_a: assert property (sfr.addr == ADDR_WATCHDOG |=> sfr_rdata == $past(s.wdog))
    else $error("watchdog register read blocked");
  // an open window alone is not enough: an indirect write must still be dropped
  wdog_locked_a: assert property (sfr.wr && sfr.addr == ADDR_WATCHDOG && !wr_ok |=>
    s.wdog == $past(s.wdog))
    else $error("locked watchdog register changed");

  toggle_c: cover property (op.done && s.tog_en && toggles);
  direct_drop_c: cover property (sfr.wr && !sfr.direct && s.lock == XPA_LK_OPEN);
  unlock_write_c: cover property (wr_ok && sfr.wr && sfr.addr == ADDR_ADDR_MODE);
  ri_move_c: cover property (move_start && xmove.use_ri);
endmodule

// *** src/xpa_pkg.sv ***
// Purpose: shared constants and types for the external data pointer and access block
// Assumes: 8-bit special function register space, one system clock
// Notes:   every offset, field position and reset value lives here
package xpa_pkg;

  // register addresses in the special function space
  localparam logic [7:0] ADDR_PTR0_LOW   = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HIGH  = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LOW   = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HIGH  = 8'h85;
  localparam logic [7:0] ADDR_PTR_SELECT = 8'h86;
  localparam logic [7:0] ADDR_CLK_STRETCH = 8'h8E;
  localparam logic [7:0] ADDR_PTR0_EXT   = 8'h93;
  localparam logic [7:0] ADDR_PTR1_EXT   = 8'h95;
  localparam logic [7:0] ADDR_IND_MIDDLE = 8'h9A;
  localparam logic [7:0] ADDR_ADDR_MODE  = 8'h9D;
  localparam logic [7:0] ADDR_RESERVED   = 8'hC6;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hC7;
  localparam logic [7:0] ADDR_WATCHDOG   = 8'hD8;
  localparam logic [7:0] ADDR_IND_UPPER  = 8'hEA;

  // unlock key values, written in this order
  localparam logic [7:0] UNLOCK_FIRST  = 8'hAA;
  localparam logic [7:0] UNLOCK_SECOND = 8'h55;

  // reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_POINTER   = 16'h0000;
  localparam logic [7:0]  RST_CLK_STRETCH = 8'h03;

  // field positions of the pointer select register
  localparam int SEL_BIT  = 0;
  localparam int TOGGLE_EN_BIT = 5;
  localparam int DIR0_BIT = 6;
  localparam int DIR1_BIT = 7;
  // stretch field and address mode field
  localparam int STRETCH_W  = 3;
  localparam int AMODE_W    = 2;
  localparam int AMODE_FLAT = 1;

  // pointer-related instruction kinds reported by the core
  typedef enum logic [2:0] {
    XPA_OP_NONE     = 3'h0,
    XPA_OP_INC      = 3'h1,
    XPA_OP_LOAD     = 3'h2,
    XPA_OP_MOVC     = 3'h3,
    XPA_OP_JMP      = 3'h4,
    XPA_OP_MOVX_PTR = 3'h5,
    XPA_OP_MOVX_RI  = 3'h6,
    XPA_OP_OTHER    = 3'h7
  } xpa_op_kind_t;

  // unlock sequence states
  typedef enum logic [3:0] {
    XPA_LK_IDLE = 4'h1,
    XPA_LK_KEY1 = 4'h2,
    XPA_LK_KEY2 = 4'h4,
    XPA_LK_OPEN = 4'h8
  } xpa_lock_t;

  typedef struct packed {
    logic       wr;
    logic       direct;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xpa_sfr_req_t;

  typedef struct packed {
    logic         done;
    xpa_op_kind_t kind;
  } xpa_op_t;

  typedef struct packed {
    logic       req;
    logic       write;
    logic       use_ri;
    logic [7:0] ri_value;
  } xpa_xmove_t;

endpackage

// *** src/xpa_strobe.sv ***
// Purpose: stretched read or write strobe for one external data move
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes:   width is latched at start so a later stretch change hits the next move
`timescale 1ns/100ps
module xpa_strobe #(
  parameter int STRETCH_W = 3
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 start,
  input  wire logic                 write,
  input  wire logic [STRETCH_W-1:0] width,
  output logic                      rd_strobe,
  output logic                      wr_strobe,
  output logic                      busy,
  output logic                      done
);
  import xpa_pkg::*;

  typedef struct packed {
    logic                 busy;
    logic                 write;
    logic [STRETCH_W-1:0] cnt;
  } xpa_strobe_state_t;

  xpa_strobe_state_t s;
  xpa_strobe_state_t next_s;

  // strobe lasts width plus one clocks, counted down to zero
  always_comb begin
    next_s = s;
    if (!s.busy && start) begin
      next_s.busy  = 1'b1;
      next_s.write = write;
      next_s.cnt   = width;
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // strobes exist only inside a move
  assign rd_strobe = s.busy & ~s.write;
  assign wr_strobe = s.busy & s.write;
  assign busy      = s.busy;
  assign done      = s.busy && (s.cnt == '0);

  // helper: count strobe cycles of each move
  logic [STRETCH_W:0]   hi_cnt;
  logic [STRETCH_W-1:0] w_latched;
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_cnt    <= '0;
      w_latched <= '0;
    end else if (!s.busy && start) begin
      hi_cnt    <= '0;
      w_latched <= width;
    end else if (s.busy) begin
      hi_cnt <= hi_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  strobe_width_a: assert property ($fell(s.busy) |-> hi_cnt == w_latched + 1'b1)
    else $error("strobe width differs from stretch field plus one");
  strobe_start_a: assert property (!s.busy && start |=> (rd_strobe ^ wr_strobe))
    else $error("move start did not raise exactly one strobe");
  long_strobe_c: cover property (!s.busy && start && width == 3'h7);
endmodule

// *** testbench/xpa_xmem_model.sv ***
// Purpose: far-side observer of external data moves (memory or slow device)
// Assumes: strobes are flop-driven levels and fall low between two moves
// Notes:   the block carries no data bus, so only width, address, kind and a move count are kept
`timescale 1ns/100ps
module xpa_xmem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [23:0] addr,
  output logic [3:0]       width,
  output logic [23:0]      last_addr,
  output logic             last_wr,
  output logic [7:0]       moves
);
  logic [3:0] cnt;

  // strobe pulse measure
  // address and kind are latched in the first strobe cycle, width when it drops
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 4'h0;
      width <= 4'h0;
      last_addr <= 24'h000000;
      last_wr <= 1'b0;
      moves <= 8'h00;
    end else if (rd | wr) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h0) begin
        moves <= moves + 8'h01;
        last_addr <= addr;
        last_wr <= wr;
      end
    end else if (cnt != 4'h0) begin
      width <= cnt;
      cnt <= 4'h0;
    end
  end
endmodule

// *** testbench/xdata_pointer_access_control_tb.sv ***
// Purpose: self-checking bench for the external data pointer and access block
// Assumes: every register write is reported as a finished instruction
// Notes:   inputs change on the falling edge, outputs are judged there too
`timescale 1ns/100ps
module xdata_pointer_access_control_tb;
  import xpa_pkg::*;

  logic         clk;
  logic         rst;
  xpa_sfr_req_t sfr;
  xpa_op_t      op;
  logic [23:0]  load_value;
  xpa_xmove_t   xmove;
  logic [7:0]   sfr_rdata;
  logic [23:0]  ext_data_address;
  logic [23:0]  active_pointer;
  logic         ext_read_strobe;
  logic         ext_write_strobe;
  logic         xmove_busy;
  logic         xmove_done;
  logic [1:0]   address_mode;
  logic         protect_open;
  logic [3:0]   m_width;
  logic [23:0]  m_addr;
  logic         m_wr;
  logic [7:0]   m_moves;
  logic         wr_direct;
  int           fail_count;
  int           n_compared;

  xpa_core dut_u (
    .clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata), .op(op),
    .load_value(load_value), .xmove(xmove), .ext_data_address(ext_data_address),
    .ext_read_strobe(ext_read_strobe), .ext_write_strobe(ext_write_strobe),
    .xmove_busy(xmove_busy), .xmove_done(xmove_done), .active_pointer(active_pointer),
    .address_mode(address_mode), .protect_open(protect_open)
  );

  xpa_xmem_model xmem_u (
    .clk(clk), .rst(rst), .rd(ext_read_strobe), .wr(ext_write_strobe),
    .addr(ext_data_address), .width(m_width), .last_addr(m_addr), .last_wr(m_wr),
    .moves(m_moves)
  );

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  // one register write, reported as a finished instruction, direct unless wr_direct is cleared
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    sfr = '{wr: 1'b1, direct: wr_direct, addr: a, wdata: d};
    op = '{done: 1'b1, kind: XPA_OP_OTHER};
    @(negedge clk);
    sfr.wr = 1'b0;
    op.done = 1'b0;
    // let an edge pass so the next call never re-raises the write and done pulse in one step
    @(negedge clk);
  endtask

  // read data is registered, so it is judged one edge after the address
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    sfr.addr = a;
    @(negedge clk);
    check({16'h0000, sfr_rdata}, {16'h0000, exp});
  endtask

  task automatic op_run(input xpa_op_kind_t k, input logic [23:0] lv);
    op = '{done: 1'b1, kind: k};
    load_value = lv;
    @(negedge clk);
    op.done = 1'b0;
    @(negedge clk);
  endtask

  // one external move, waited out under a bound, then judged at the far side
  task automatic move(input logic w, input logic ri, input logic [7:0] rv,
                      input logic [23:0] exp_a, input logic [3:0] exp_w);
    xmove = '{req: 1'b1, write: w, use_ri: ri, ri_value: rv};
    @(negedge clk);
    xmove.req = 1'b0;
    for (int i = 0; i < 20 && xmove_busy !== 1'b0; i++) @(negedge clk);
    if (xmove_busy !== 1'b0) begin
      fail_count++;
      results();
    end
    @(negedge clk);
    check(m_addr, exp_a);
    check({20'h0, m_width}, {20'h0, exp_w});
    check({23'h0, m_wr}, {23'h0, w});
    check({22'h0, ext_read_strobe, ext_write_strobe}, 24'h0);
  endtask

  task automatic t_reset();
    logic [7:0] ra [0:11];
    logic [7:0] rv [0:11];
    ra = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8E, 8'h93, 8'h95, 8'h9A, 8'h9D,
           8'hD8, 8'hEA};
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
           8'h00, 8'h00};
    for (int i = 0; i < 12; i++) rd_reg(ra[i], rv[i]);
  endtask

  // fills pointers and extensions, then forms addresses from both pointers
  task automatic t_regs_and_moves();
    logic [7:0] wa [0:7];
    logic [7:0] wv [0:7];
    wa = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h93, 8'h95, 8'h9A, 8'hEA};
    wv = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'hDE, 8'hF1};
    for (int i = 0; i < 8; i++) wr_reg(wa[i], wv[i]);
    for (int i = 0; i < 8; i++) rd_reg(wa[i], wv[i]);
    rd_reg(8'hC6, 8'h00);
    rd_reg(8'h80, 8'h00);
    check(active_pointer, 24'h9A3412);
    move(1'b0, 1'b0, 8'h00, 24'h9A3412, 4'h4);
    wr_reg(8'h86, 8'h01);
    check(active_pointer, 24'hBC7856);
    move(1'b1, 1'b0, 8'h00, 24'hBC7856, 4'h4);
    move(1'b0, 1'b1, 8'h5C, 24'hF1DE5C, 4'h4);
  endtask

  task automatic t_inc();
    wr_reg(8'h86, 8'h41);
    op_run(XPA_OP_INC, 24'h0);
    check(active_pointer, 24'hBC7857);
    wr_reg(8'h86, 8'h81);
    op_run(XPA_OP_INC, 24'h0);
    check(active_pointer, 24'hBC7856);
    wr_reg(8'h86, 8'h40);
    wr_reg(8'h82, 8'h00);
    wr_reg(8'h83, 8'h00);
    op_run(XPA_OP_INC, 24'h0);
    check(active_pointer, 24'h9AFFFF);
    wr_reg(8'h86, 8'h80);
    op_run(XPA_OP_INC, 24'h0);
    check(active_pointer, 24'h9A0000);
  endtask

  task automatic t_toggle();
    xpa_op_kind_t ks [0:3];
    logic         s;
    ks = '{XPA_OP_INC, XPA_OP_LOAD, XPA_OP_MOVC, XPA_OP_MOVX_PTR};
    s = 1'b0;
    wr_reg(8'h86, 8'h20);
    for (int i = 0; i < 4; i++) begin
      op_run(ks[i], 24'h77ABCD);
      s = ~s;
      rd_reg(8'h86, {7'h10, s});
    end
    op_run(XPA_OP_JMP, 24'h0);
    rd_reg(8'h86, 8'h20);
    rd_reg(8'h84, 8'hCD);
    rd_reg(8'h85, 8'hAB);
    wr_reg(8'h86, 8'h00);
    for (int i = 0; i < 4; i++) begin
      op_run(ks[i], 24'h000000);
      rd_reg(8'h86, 8'h00);
    end
  endtask

  // every stretch setting, changed between consecutive moves
  task automatic t_stretch();
    logic [7:0] n0;
    n0 = m_moves;
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h8E, {5'h00, 3'(i)});
      move(1'(i), 1'b1, 8'(i), {16'hF1DE, 8'(i)}, 4'(i + 1));
    end
    check({16'h0, m_moves}, {16'h0, n0 + 8'h08});
  endtask

  task automatic t_unlock();
    wr_reg(8'h9D, 8'h02);
    rd_reg(8'h9D, 8'h00);
    wr_reg(8'hC7, 8'hAA);
    wr_reg(8'h82, 8'h11);
    repeat (5) @(negedge clk);
    wr_reg(8'hC7, 8'h55);
    check({23'h0, protect_open}, 24'h1);
    wr_reg(8'h9D, 8'h02);
    check({22'h0, address_mode, protect_open}, 24'h4);
    rd_reg(8'h9D, 8'h02);
    wr_reg(8'h9D, 8'h00);
    rd_reg(8'h9D, 8'h02);
    wr_reg(8'hC7, 8'hAA);
    wr_reg(8'hC7, 8'h55);
    op_run(XPA_OP_OTHER, 24'h0);
    wr_reg(8'hD8, 8'h5A);
    rd_reg(8'hD8, 8'h00);
    wr_reg(8'hC7, 8'hAA);
    wr_reg(8'hC7, 8'h55);
    wr_reg(8'hD8, 8'h5A);
    rd_reg(8'hD8, 8'h5A);
    wr_reg(8'hC7, 8'hAA);
    wr_reg(8'hC7, 8'h55);
    wr_direct = 1'b0;
    wr_reg(8'h9D, 8'h00);
    wr_direct = 1'b1;
    rd_reg(8'h9D, 8'h02);
    op_run(XPA_OP_LOAD, 24'h456789);
    check(active_pointer, 24'h456789);
  endtask

  // inputs idle from time zero, reset held for 16 edges
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst = 1'b1;
    wr_direct = 1'b1;
    sfr = '0;
    op = '0;
    xmove = '0;
    load_value = 24'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_regs_and_moves();
    t_inc();
    t_toggle();
    t_stretch();
    t_unlock();
    results();
  end
endmodule
